// ---- design/fcip_cal_view.v ----
`timescale 1ns/1ns
`include "fcip_consts.vh"
// Shadow copy of the calibration bytes taken as they are written.
module fcip_cal_view (
    clock,
    wr_en,
    wr_addr,
    wr_data,
    temp_offset_cal,
    watchdog_cal,
    serial_number
);
    input wire clock;
    input wire wr_en;
    input wire [`FCIP_PAGE_AW-1:0] wr_addr;
    input wire [7:0] wr_data;
    output reg [11:0] temp_offset_cal;
    output reg [15:0] watchdog_cal;
    output reg [31:0] serial_number;

    initial begin
        temp_offset_cal = 12'hfff;
        watchdog_cal = 16'hffff;
        serial_number = 32'hffffffff;
    end

    // No reset: these mirror nonvolatile bytes
    always @(posedge clock) begin
        if (wr_en) begin
            case (wr_addr)
                `FCIP_OFS_TSCAL_HI: temp_offset_cal[11:8] <= wr_data[`FCIP_TS_HI_BITS-1:0];
                `FCIP_OFS_TSCAL_LO: temp_offset_cal[7:0] <= wr_data;
                `FCIP_OFS_WDCAL_HI: watchdog_cal[15:8] <= wr_data;
                `FCIP_OFS_WDCAL_LO: watchdog_cal[7:0] <= wr_data;
                `FCIP_OFS_SERIAL3: serial_number[31:24] <= wr_data;
                `FCIP_OFS_SERIAL2: serial_number[23:16] <= wr_data;
                `FCIP_OFS_SERIAL1: serial_number[15:8] <= wr_data;
                `FCIP_OFS_SERIAL0: serial_number[7:0] <= wr_data;
                default: begin
                end
            endcase
        end
    end
endmodule

// ---- design/fcip_consts.vh ----
// How it works
// - The temperature offset calibration high byte sits at info offset 3a, the low byte at 3b.
// - The two temperature bytes together give one 12-bit sensor offset calibration value.
// - No reset of any kind changes a calibration or serial number byte.
// - The watchdog calibration high byte sits at info offset 7e, the low byte at 7f.
// - With those reload values the watchdog times out after about one second.
// - A unique four-byte serial number occupies info offsets 1c to 1f.
// - The serial number is stored most significant byte first, byte 3 at 1c, byte 0 at 1f.
`ifndef FCIP_CONSTS_VH
`define FCIP_CONSTS_VH
`define FCIP_PAGE_AW 7
`define FCIP_PAGE_WORDS 128
`define FCIP_OFS_SERIAL3 7'h1c
`define FCIP_OFS_SERIAL2 7'h1d
`define FCIP_OFS_SERIAL1 7'h1e
`define FCIP_OFS_SERIAL0 7'h1f
`define FCIP_OFS_TSCAL_HI 7'h3a
`define FCIP_OFS_TSCAL_LO 7'h3b
`define FCIP_OFS_WDCAL_HI 7'h7e
`define FCIP_OFS_WDCAL_LO 7'h7f
`define FCIP_TS_HI_BITS 4
`define FCIP_WD_UPPER_VAL 8'h00
`define FCIP_ERASED_BYTE 8'hff
`define FCIP_HTRANS_NONSEQ 2'b10
`define FCIP_HSIZE_WORD 3'b010
`endif

// ---- design/fcip_info_page.v ----
`timescale 1ns/1ns
`include "fcip_consts.vh"
// Info page behind AHB-Lite: byte offset N of the page is word address 4*N.
module fcip_info_page (
    clock,
    rst_n,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    temp_offset_cal_reg,
    watchdog_reload_upper_reg,
    watchdog_reload_high_reg,
    watchdog_reload_low_reg,
    serial_number_reg
);
    input wire clock;
    input wire rst_n;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output reg hreadyout;
    output reg hresp;
    output reg [11:0] temp_offset_cal_reg;
    output reg [7:0] watchdog_reload_upper_reg;
    output reg [7:0] watchdog_reload_high_reg;
    output reg [7:0] watchdog_reload_low_reg;
    output reg [31:0] serial_number_reg;

    reg wr_pend_reg;
    reg [`FCIP_PAGE_AW-1:0] wr_addr_reg;
    wire [`FCIP_PAGE_AW-1:0] rd_addr;
    wire [7:0] rd_byte;
    wire [7:0] rd_fwd;
    wire [11:0] ts_cal;
    wire [15:0] wd_cal;
    wire [31:0] sn;
    wire access;
    wire in_page;

    // Whole page decodes to 0x000-0x1fc; above that reads zero, writes drop
    function page_hit;
        input [31:0] a;
        begin
            page_hit = (a[31:`FCIP_PAGE_AW+2] == 0);
        end
    endfunction

    assign access = hsel && hready && (htrans == `FCIP_HTRANS_NONSEQ);
    assign in_page = page_hit(haddr);
    assign rd_addr = haddr[`FCIP_PAGE_AW+1:2];
    // A pipelined read in a write's data phase would otherwise see the byte before it commits
    assign rd_fwd = (wr_pend_reg && (wr_addr_reg == rd_addr)) ? hwdata[7:0] : rd_byte;

    fcip_page_mem u_mem (
        .clock(clock),
        .wr_en(wr_pend_reg),
        .wr_addr(wr_addr_reg),
        .wr_data(hwdata[7:0]),
        .rd_addr(rd_addr),
        .rd_data(rd_byte)
    );

    fcip_cal_view u_view (
        .clock(clock),
        .wr_en(wr_pend_reg),
        .wr_addr(wr_addr_reg),
        .wr_data(hwdata[7:0]),
        .temp_offset_cal(ts_cal),
        .watchdog_cal(wd_cal),
        .serial_number(sn)
    );

    // Zero-wait slave: read data lands in the data phase, writes commit at its end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= {`FCIP_PAGE_AW{1'b0}};
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= access && hwrite && in_page;
            if (access) begin
                wr_addr_reg <= rd_addr;
            end
            if (access && !hwrite) begin
                hrdata <= in_page ? {24'h000000, rd_fwd} : 32'h00000000;
            end
        end
    end

    // Calibration outputs; cleared on reset only at the port, the page itself keeps them
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            temp_offset_cal_reg <= 12'h000;
            watchdog_reload_upper_reg <= `FCIP_WD_UPPER_VAL;
            watchdog_reload_high_reg <= 8'h00;
            watchdog_reload_low_reg <= 8'h00;
            serial_number_reg <= 32'h00000000;
        end else begin
            temp_offset_cal_reg <= ts_cal;
            watchdog_reload_upper_reg <= `FCIP_WD_UPPER_VAL;
            watchdog_reload_high_reg <= wd_cal[15:8];
            watchdog_reload_low_reg <= wd_cal[7:0];
            serial_number_reg <= sn;
        end
    end
endmodule

// ---- design/fcip_page_mem.v ----
`timescale 1ns/1ns
`include "fcip_consts.vh"
// Nonvolatile page model: the array has no reset path at all, so it survives every reset.
module fcip_page_mem (
    clock,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input wire clock;
    input wire wr_en;
    input wire [`FCIP_PAGE_AW-1:0] wr_addr;
    input wire [7:0] wr_data;
    input wire [`FCIP_PAGE_AW-1:0] rd_addr;
    output wire [7:0] rd_data;

    reg [7:0] page_mem [0:`FCIP_PAGE_WORDS-1];
    integer i;

    initial begin
        for (i = 0; i < `FCIP_PAGE_WORDS; i = i + 1) begin
            page_mem[i] = `FCIP_ERASED_BYTE;
        end
    end

    always @(posedge clock) begin
        if (wr_en) begin
            page_mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = page_mem[rd_addr];
endmodule

// ---- tb/fcip_info_page_assertions.sv ----
`timescale 1ns/1ns
module fcip_chk (
    input logic clock,
    input logic rst_n,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic [11:0] temp_offset_cal_reg,
    input logic [7:0] watchdog_reload_upper_reg,
    input logic [7:0] watchdog_reload_high_reg,
    input logic [31:0] serial_number_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire rd = hsel && hready && htrans == 2'b10 && !hwrite;
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall");
    a_rd_upper: assert property (rd |=> hrdata[31:8] == 24'h0) else $error("high bits");
    a_oob_zero: assert property (rd && haddr >= 32'h200 |=> hrdata == 32'h0)
        else $error("oob read");
    a_temp_hi: assert property (rd && haddr == 32'h0e8 |=>
        hrdata[3:0] == temp_offset_cal_reg[11:8]) else $error("temp hi");
    a_wdt_high: assert property (rd && haddr == 32'h1f8 |=>
        hrdata[7:0] == watchdog_reload_high_reg) else $error("wdt hi");
    a_serial_msb: assert property (rd && haddr == 32'h070 |=>
        hrdata[7:0] == serial_number_reg[31:24]) else $error("serial");
    a_upper_zero: assert property (watchdog_reload_upper_reg == 8'h00)
        else $error("wdt upper");
    a_temp_lo: assert property (rd && haddr == 32'h0ec |=>
        hrdata[7:0] == temp_offset_cal_reg[7:0]) else $error("temp lo");
    cover property (rd && haddr == 32'h070);
    cover property (hsel && hwrite && htrans == 2'b10);
    cover property (rd && haddr >= 32'h200);
endmodule
bind fcip_info_page fcip_chk i_chk (.*);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, serial_number_reg, q;
    logic [11:0] temp_offset_cal_reg;
    logic [7:0] watchdog_reload_upper_reg, watchdog_reload_high_reg, watchdog_reload_low_reg;
    int errors = 0, n_tests = 0;
    logic [31:0] ad [8] = '{32'h0e8, 32'h0ec, 32'h1f8, 32'h1fc,
        32'h070, 32'h074, 32'h078, 32'h07c};
    logic [7:0] dv [8] = '{8'ha5, 8'h3c, 8'h12, 8'h34, 8'h10, 8'h11, 8'h12, 8'h13};
    fcip_info_page i_dut (.hready(hreadyout), .*);
    initial forever #20 clock = ~clock;
    task automatic cmp(input string s, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        // Let the shadow outputs catch up before anything reads them
        if (w) repeat (3) @(posedge clock);
    endtask
    task automatic rd(input logic [31:0] a, e);
        xfer(0, a, 0);
        cmp("hrdata", e, q);
    endtask
    task results;
        if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #80000;
        errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        for (int i = 0; i < 8; i++) xfer(1, ad[i], {24'h0, dv[i]});
        for (int i = 0; i < 8; i++) rd(ad[i], {24'h0, dv[i]});
        cmp("temp", 32'h53c, 32'(temp_offset_cal_reg));
        cmp("wdt_upper", 32'h0, 32'(watchdog_reload_upper_reg));
        cmp("wdt", 32'h1234, {16'h0, watchdog_reload_high_reg, watchdog_reload_low_reg});
        cmp("serial", 32'h10111213, serial_number_reg);
        // Out-of-page alias of the temp high byte must not land in the page
        xfer(1, 32'h2e8, 32'h0);
        rd(32'h2e8, 32'h0);
        rst_n <= 0;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        for (int i = 0; i < 8; i++) rd(ad[i], {24'h0, dv[i]});
        cmp("temp_rst", 32'h53c, 32'(temp_offset_cal_reg));
        cmp("wdt_rst", 32'h1234, {16'h0, watchdog_reload_high_reg, watchdog_reload_low_reg});
        cmp("serial_rst", 32'h10111213, serial_number_reg);
        results();
    end
endmodule
